// [include/scb_defs.svh]
// Constants for the clock buffer SMBus target and configuration bytes
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH
// Register indices
`define SCB_IDX_OE 8'h00
`define SCB_IDX_MODE 8'h01
`define SCB_IDX_SLEW 8'h02
`define SCB_IDX_BCNT 8'h08
// Reset values
`define SCB_OE_RST 8'hff
`define SCB_MODE_RST 8'h02
`define SCB_SLEW_RST 8'hff
`define SCB_BCNT_RST 8'h08
`define SCB_UNMAPPED 8'h00
// Reserved bits that read as one in bytes 0 and 2
`define SCB_RSVD_ONES 8'h22
// Writable bits of byte 1, reserved bit 2 reads zero
`define SCB_MODE_WMASK 8'h3b
// Byte 1 fields
`define SCB_MODE_RB 7:6
`define SCB_MODE_SW 5
`define SCB_MODE_WR 4:3
`define SCB_MODE_LOW 5:0
`define SCB_AMP 1:0
// Per-output bit positions: outputs 5..0
`define SCB_PICK6(b) {b[7], b[6], b[4], b[3], b[2], b[0]}
// Target addresses by address-select level
`define SCB_ADDR_LO 7'h6b
`define SCB_ADDR_MID 7'h6c
`define SCB_ADDR_HI 7'h6d
`define SCB_SEL_LO 2'h0
`define SCB_SEL_MID 2'h1
// Address byte fields
`define SCB_ADDR_FLD 7:1
`define SCB_RW_BIT 0
// Bit counts and strap settle time
`define SCB_BYTE_BITS 4'd8
`define SCB_LAST_BIT 4'd7
`define SCB_STRAP_WAIT 2'd3
// Synchroniser reset image: scl, sda, sel, mode, enable pins
`define SCB_SYNC_INIT 12'hc3f
`endif

// [include/scb_pkg.sv]
// Shared types for the clock buffer SMBus target
package scb_pkg;
  // Bit-level bus state
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK}
    scb_state_e;
  // Which byte of a transfer is being received
  typedef enum logic [1:0] {PH_ADDR, PH_IDX, PH_CNT, PH_DATA} scb_phase_e;
  // Register write strobe with index and data
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } scb_wr_s;
  // Controls sent to the clock outputs
  typedef struct packed {
    logic [5:0] out_run;
    logic [5:0] edge_speed;
    logic [1:0] amplitude;
    logic [1:0] pll_mode;
  } scb_cfg_s;
endpackage : scb_pkg

// [hw/scb_sync.sv]
// Two-flop synchroniser for pins outside the block clock
`timescale 1ns/100ps
`include "scb_defs.svh"
module scb_sync #(
  parameter int W = 12,
  parameter logic [W-1:0] INIT = `SCB_SYNC_INIT
) (
  input wire logic mclk, // Block clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta; // First stage, read only by q

  // Two stages, idle levels under reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : scb_sync

// [hw/scb_cfg_regs.sv]
// Configuration bytes and output gating of the clock buffer
`timescale 1ns/100ps
`include "scb_defs.svh"
module scb_cfg_regs (
  input wire logic mclk, // Block clock
  input wire logic rst, // Synchronous reset, high
  input wire scb_pkg::scb_wr_s wr, // Write strobe from the target
  input wire logic [7:0] rd_idx, // Read index
  input wire logic [1:0] mode_latched, // Mode pins caught at startup
  input wire logic [5:0] pin_en_n, // Synchronised enable pins, low on
  output logic [7:0] rd_data, // Byte at the read index
  output logic [7:0] bcnt, // Block read count byte
  output scb_pkg::scb_cfg_s cfg // Output controls
);
  logic [7:0] oe_byte; // Output enable byte
  logic [7:0] mode_byte; // Mode and amplitude byte, low six bits
  logic [7:0] slew_byte; // Edge speed byte
  logic [5:0] oe_bits; // Enable per output
  logic [5:0] run; // Output running per output
  logic [1:0] wr_amp; // Amplitude field of write data

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Gathers the six per-output bits of a byte
  function automatic logic [5:0] pick6(input logic [7:0] b);
    pick6 = `SCB_PICK6(b);
  endfunction : pick6

  // Byte writes from the bus
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      oe_byte <= `SCB_OE_RST;
      mode_byte <= `SCB_MODE_RST;
      slew_byte <= `SCB_SLEW_RST;
      bcnt <= `SCB_BCNT_RST;
    end
    else if (wr.en)
    begin
      if (wr.idx == `SCB_IDX_OE)
        oe_byte <= wr.data | `SCB_RSVD_ONES;
      else if (wr.idx == `SCB_IDX_MODE)
        mode_byte <= wr.data & `SCB_MODE_WMASK;
      else if (wr.idx == `SCB_IDX_SLEW)
        slew_byte <= wr.data | `SCB_RSVD_ONES;
      else if (wr.idx == `SCB_IDX_BCNT)
        bcnt <= wr.data;
    end
  end

  // Read mux; the mode readback comes from the strap latch
  always_comb
  begin
    if (rd_idx == `SCB_IDX_OE)
      rd_data = oe_byte;
    else if (rd_idx == `SCB_IDX_MODE)
      rd_data = {mode_latched, mode_byte[`SCB_MODE_LOW]};
    else if (rd_idx == `SCB_IDX_SLEW)
      rd_data = slew_byte;
    else if (rd_idx == `SCB_IDX_BCNT)
      rd_data = bcnt;
    else
      rd_data = `SCB_UNMAPPED;
  end

  assign oe_bits = pick6(oe_byte);
  assign wr_amp = wr.data[`SCB_AMP];

  // A cleared enable bit holds the pair low whatever the pin says
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_gate
      assign run[i] = oe_bits[i] & ~pin_en_n[i];
    end
  endgenerate

  // Mode source: latched straps unless software control is set
  assign cfg.pll_mode = mode_byte[`SCB_MODE_SW] ?
    mode_byte[`SCB_MODE_WR] : mode_latched;
  assign cfg.out_run = run;
  assign cfg.edge_speed = pick6(slew_byte);
  assign cfg.amplitude = mode_byte[`SCB_AMP];

  chk_gate_low: assert property (
    (wr.en && wr.idx == `SCB_IDX_OE && wr.data == 8'h00)
    |=> cfg.out_run == 6'h00)
    else $error("cleared enables left an output running");
  chk_rsvd_read: assert property (
    (rd_idx == `SCB_IDX_OE || rd_idx == `SCB_IDX_SLEW)
    |-> (rd_data & `SCB_RSVD_ONES) == `SCB_RSVD_ONES)
    else $error("reserved bits did not read one");
  chk_mode_src: assert property (
    !mode_byte[`SCB_MODE_SW] |-> cfg.pll_mode == mode_latched)
    else $error("mode not taken from straps");
  chk_mode_ignore: assert property (
    (wr.en && wr.idx == `SCB_IDX_MODE && !wr.data[`SCB_MODE_SW])
    |=> cfg.pll_mode == mode_latched)
    else $error("written mode bits acted without software control");
  chk_mode_rb: assert property (
    rd_idx == `SCB_IDX_MODE |-> rd_data[`SCB_MODE_RB] == mode_latched)
    else $error("mode readback differs from straps");
  chk_amp_wr: assert property (
    (wr.en && wr.idx == `SCB_IDX_MODE) |=> cfg.amplitude == $past(wr_amp))
    else $error("amplitude write not applied");
  chk_bcnt_wr: assert property (
    (wr.en && wr.idx == `SCB_IDX_BCNT) |=> bcnt == $past(wr.data))
    else $error("count byte write not applied");
endmodule : scb_cfg_regs

// [hw/scb_target.sv]
// SMBus target of the clock buffer with indexed block write and read
`timescale 1ns/100ps
`include "scb_defs.svh"
// Contract
// - Acknowledge address, index, count, each data byte within the count
// - Send count first, then bytes from index
// - Count byte eight sets block read length
// - Target address comes from latched select pin
// - Byte 0 enables default one, reserved read one
// - Cleared enable forces output pair low
// - Byte 1 top bits report latched mode
// - Byte 1 bit 5 picks mode source
// - Written mode bits idle unless bit 5 set
// - Byte 1 low bits pick output amplitude
// - Byte 2 edge speed per output, default fast
module scb_target (
  input wire logic mclk, // Block clock, 20 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Bus data drive value, always low
  output logic sda_oe_n, // Bus data drive enable, low drives
  input wire logic [1:0] addr_sel, // Address-select pin level code
  input wire logic [1:0] pll_mode_pins, // Mode strap pins
  input wire logic [5:0] out_pin_en_n, // Output enable pins, low on
  output scb_pkg::scb_cfg_s cfg // Output controls
);
  logic [11:0] sync_q; // Synchronised pins
  logic scl_s; // Synchronised bus clock
  logic sda_s; // Synchronised bus data
  logic [1:0] sel_s; // Synchronised address select
  logic [1:0] mode_s; // Synchronised mode straps
  logic [5:0] pin_en_n_s; // Synchronised enable pins
  logic scl_d; // Bus clock one cycle back
  logic sda_d; // Bus data one cycle back
  logic scl_rise; // Bus clock rising
  logic scl_fall; // Bus clock falling
  logic bus_start; // Start or repeated start seen
  logic bus_stop; // Stop seen
  logic [1:0] strap_cnt; // Settle count before latching straps
  logic strap_done; // Straps latched, bus live
  logic [6:0] my_addr; // Own target address
  logic [1:0] mode_latched; // Mode caught at startup
  scb_pkg::scb_state_e state; // Bit-level state
  scb_pkg::scb_phase_e phase; // Byte being received
  logic rd; // Read address was taken
  logic host_ack; // Host acknowledged the last byte
  logic [3:0] bitcnt; // Bits done in this byte
  logic [7:0] shift; // Receive and transmit shifter
  logic [7:0] index; // Register index
  logic [7:0] remain; // Data bytes left in a block write
  scb_pkg::scb_wr_s wr; // Register write strobe
  logic [7:0] rd_data; // Byte at the current index
  logic [7:0] bcnt; // Block read count

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Maps the address-select level to a target address
  function automatic logic [6:0] addr_of(input logic [1:0] sel);
    if (sel == `SCB_SEL_LO)
      addr_of = `SCB_ADDR_LO;
    else if (sel == `SCB_SEL_MID)
      addr_of = `SCB_ADDR_MID;
    else
      addr_of = `SCB_ADDR_HI;
  endfunction : addr_of

  // All pins pass two flops before use
  scb_sync #(
    .W(12),
    .INIT(`SCB_SYNC_INIT)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({scl_i, sda_i, addr_sel, pll_mode_pins, out_pin_en_n}),
    .q(sync_q)
  );
  assign {scl_s, sda_s, sel_s, mode_s, pin_en_n_s} = sync_q;

  // Configuration bytes and output gating
  scb_cfg_regs u_regs (
    .mclk(mclk),
    .rst(rst),
    .wr(wr),
    .rd_idx(index),
    .mode_latched(mode_latched),
    .pin_en_n(pin_en_n_s),
    .rd_data(rd_data),
    .bcnt(bcnt),
    .cfg(cfg)
  );

  // Delayed copies for edge and condition detection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Data moving while the clock stays high marks start and stop
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_o = 1'b0;

  // Straps are caught once after reset, when the pins have settled
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      my_addr <= `SCB_ADDR_LO;
      mode_latched <= 2'h0;
    end
    else if (!strap_done)
    begin
      if (strap_cnt == `SCB_STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        my_addr <= addr_of(sel_s);
        mode_latched <= mode_s;
      end
      else
        strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // Bus state machine; data changes only while the clock is low
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= scb_pkg::ST_IDLE;
      phase <= scb_pkg::PH_ADDR;
      rd <= 1'b0;
      host_ack <= 1'b0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      index <= 8'h00;
      remain <= 8'h00;
      sda_oe_n <= 1'b1;
      wr <= '0;
    end
    else
    begin
      wr.en <= 1'b0;
      if (!strap_done || bus_stop)
      begin
        // Stop ends any transfer and frees the data line
        state <= scb_pkg::ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (bus_start)
      begin
        // Start or repeated start: expect an address byte
        state <= scb_pkg::ST_RX;
        phase <= scb_pkg::PH_ADDR;
        rd <= 1'b0;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          scb_pkg::ST_RX:
          begin
            if (scl_rise && bitcnt != `SCB_BYTE_BITS)
            begin
              // Sample one bit, first bit is the top one
              shift <= {shift[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == `SCB_BYTE_BITS)
            begin
              // Byte complete: acknowledge by default
              state <= scb_pkg::ST_ACK;
              sda_oe_n <= 1'b0;
              bitcnt <= 4'h0;
              case (phase)
                scb_pkg::PH_ADDR:
                begin
                  if (shift[`SCB_ADDR_FLD] != my_addr)
                  begin
                    // Not ours: stay off the bus until next start
                    state <= scb_pkg::ST_IDLE;
                    sda_oe_n <= 1'b1;
                  end
                  else
                  begin
                    rd <= shift[`SCB_RW_BIT];
                    phase <= scb_pkg::PH_IDX;
                  end
                end
                scb_pkg::PH_IDX:
                begin
                  index <= shift;
                  phase <= scb_pkg::PH_CNT;
                end
                scb_pkg::PH_CNT:
                begin
                  remain <= shift;
                  phase <= scb_pkg::PH_DATA;
                end
                default:
                begin
                  if (remain == 8'h00)
                  begin
                    // Byte beyond the count: refuse it
                    state <= scb_pkg::ST_IDLE;
                    sda_oe_n <= 1'b1;
                  end
                  else
                  begin
                    wr <= '{en: 1'b1, idx: index, data: shift};
                    index <= index + 8'h01;
                    remain <= remain - 8'h01;
                  end
                end
              endcase
            end
          end
          scb_pkg::ST_ACK:
          begin
            if (scl_fall)
            begin
              if (rd)
              begin
                // Read address taken: count byte goes out first
                state <= scb_pkg::ST_TX;
                shift <= bcnt;
                sda_oe_n <= bcnt[7];
              end
              else
              begin
                state <= scb_pkg::ST_RX;
                sda_oe_n <= 1'b1;
              end
            end
          end
          scb_pkg::ST_TX:
          begin
            if (scl_fall)
            begin
              if (bitcnt == `SCB_LAST_BIT)
              begin
                // Byte sent: release for the host answer
                state <= scb_pkg::ST_RACK;
                sda_oe_n <= 1'b1;
                bitcnt <= 4'h0;
              end
              else
              begin
                shift <= {shift[6:0], 1'b0};
                sda_oe_n <= shift[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          scb_pkg::ST_RACK:
          begin
            if (scl_rise)
              host_ack <= ~sda_s;
            else if (scl_fall)
            begin
              if (host_ack)
              begin
                // Next register byte, index steps on
                state <= scb_pkg::ST_TX;
                shift <= rd_data;
                sda_oe_n <= rd_data[7];
                index <= index + 8'h01;
              end
              else
                state <= scb_pkg::ST_IDLE;
            end
          end
          default:
          begin
            // Idle: wait for a start
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  chk_addr_miss: assert property (
    (state == scb_pkg::ST_RX && phase == scb_pkg::PH_ADDR && scl_fall
     && bitcnt == `SCB_BYTE_BITS && shift[`SCB_ADDR_FLD] != my_addr)
    |=> (state == scb_pkg::ST_IDLE && sda_oe_n))
    else $error("foreign address was acknowledged");
  chk_ctl_ack: assert property (
    (state == scb_pkg::ST_RX && scl_fall && bitcnt == `SCB_BYTE_BITS
     && (phase == scb_pkg::PH_IDX || phase == scb_pkg::PH_CNT))
    |=> !sda_oe_n [*2])
    else $error("index or count byte not acknowledged");
  chk_data_ack: assert property (
    (state == scb_pkg::ST_RX && phase == scb_pkg::PH_DATA && scl_fall
     && bitcnt == `SCB_BYTE_BITS && remain != 8'h00)
    |=> (wr.en && !sda_oe_n))
    else $error("data byte not written and acknowledged");
  chk_idx_step: assert property (
    wr.en |-> index == wr.idx + 8'h01)
    else $error("index did not advance after a write");
  chk_count_first: assert property (
    (state == scb_pkg::ST_ACK && rd && scl_fall)
    |=> (state == scb_pkg::ST_TX && shift == bcnt))
    else $error("count byte not sent first");
  chk_tx_drive: assert property (
    (state == scb_pkg::ST_TX && $stable(state)) |-> sda_oe_n == shift[7])
    else $error("data line differs from bit being sent");
  chk_next_byte: assert property (
    (state == scb_pkg::ST_RACK && scl_fall && host_ack)
    |=> (shift == $past(rd_data) && index == $past(index) + 8'h01))
    else $error("next read byte not loaded from index");
  chk_strap_hold: assert property (
    $past(strap_done) |-> $stable(my_addr))
    else $error("target address changed after latch");
endmodule : scb_target

// [tb/scb_host.sv]
// SMBus host model that clocks the bus and pulls the data line
`timescale 1ns/100ps
module scb_host (
  input wire logic mclk, // Block clock, paces the bus clock
  input wire logic sda, // Resolved data line level
  output logic scl, // Bus clock, stands high outside frames
  output logic sda_pull // High pulls the data line low
);
  // Bus idles with both lines released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Wait some block clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // One bit: drive in the low half, sample settled level in the high half
  task automatic xfer_bit(input logic d, output logic s);
    scl <= 1'b0;
    tick(1);
    sda_pull <= ~d;
    tick(3);
    scl <= 1'b1;
    tick(1);
    @(negedge mclk);
    s = sda;
    tick(3);
  endtask : xfer_bit
  // Start, or repeated start when rep is set
  task automatic start(input logic rep);
    if (rep)
    begin
      scl <= 1'b0;
      tick(1);
      sda_pull <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(4);
    end
    sda_pull <= 1'b1;
    tick(4);
  endtask : start
  // Stop: data rises while the clock is high
  task automatic stop();
    scl <= 1'b0;
    tick(1);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(4);
  endtask : stop
  // Send a byte MSB first, then read the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], s);
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  // Take a byte MSB first, then acknowledge or refuse it
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, b[i]);
    xfer_bit(~ack_it, s);
  endtask : recv_byte
endmodule : scb_host

// [tb/test_scb_target.sv]
// Self-checking bench of the clock buffer SMBus target
`timescale 1ns/100ps
module test_scb_target;
  logic mclk = 1'b0; // Block clock, 50 ns
  logic rst = 1'b1; // Synchronous reset
  logic [1:0] addr_sel = 2'h0; // Address-select code
  logic [1:0] strap = 2'h2; // Mode straps
  logic [5:0] out_pin_en_n = 6'h00; // Enable pins, all on
  logic [6:0] dev_addr = 7'h6b; // Address the bench talks to
  wire logic scl; // Bus clock from the host
  wire logic sda_pull; // Host pulls data low
  logic sda_o; // Design drive value
  logic sda_oe_n; // Design drive enable
  wire logic sda; // Wire with pull-up
  scb_pkg::scb_cfg_s cfg; // Output controls
  int fails = 0; // Mismatches
  int comparisons = 0; // Comparisons made
  // Open-drain wire: low if anyone drives
  assign sda = (sda_oe_n | sda_o) & ~sda_pull;
  // Clock
  always #25 mclk = ~mclk;
  scb_host i_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  scb_target i_dut (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
    .pll_mode_pins(strap), .out_pin_en_n(out_pin_en_n), .cfg(cfg));
  // Print counts and verdict, then end
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Byte comparison
  task automatic check_byte(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_byte
  // Reset with a given address-select code, then settle
  task automatic do_reset(input logic [1:0] sel);
    addr_sel <= sel;
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask : do_reset
  // Send one byte and compare its acknowledge
  task automatic send_chk(input logic [7:0] b, input logic exp);
    logic ack;
    i_host.send_byte(b, ack);
    check_byte({7'h0, ack}, {7'h0, exp}, "ack");
  endtask : send_chk
  // Block write; bytes past the count must be refused
  task automatic bus_write(input logic [7:0] idx, cnt, input logic [7:0] d[$]);
    i_host.start(1'b0);
    send_chk({dev_addr, 1'b0}, 1'b1);
    send_chk(idx, 1'b1);
    send_chk(cnt, 1'b1);
    foreach (d[i])
      send_chk(d[i], i < cnt);
    i_host.stop();
  endtask : bus_write
  // Block read: count byte first, then bytes from the index
  task automatic bus_read(input logic [7:0] idx, cnt, input logic [7:0] e[$]);
    logic [7:0] b;
    i_host.start(1'b0);
    send_chk({dev_addr, 1'b0}, 1'b1);
    send_chk(idx, 1'b1);
    i_host.start(1'b1);
    send_chk({dev_addr, 1'b1}, 1'b1);
    i_host.recv_byte(1'b1, b);
    check_byte(b, cnt, "count");
    foreach (e[i])
    begin
      i_host.recv_byte(i != e.size() - 1, b);
      check_byte(b, e[i], "read");
    end
    i_host.stop();
  endtask : bus_read
  // Address probe: acknowledge only for the latched address
  task automatic probe(input logic [6:0] a, input logic exp);
    i_host.start(1'b0);
    send_chk({a, 1'b0}, exp);
    i_host.stop();
  endtask : probe
  // Reset values in registers and at the output controls
  task automatic sc_defaults();
    check_byte({2'h0, cfg.out_run}, 8'h3f, "run");
    check_byte({2'h0, cfg.edge_speed}, 8'h3f, "slew");
    check_byte({6'h0, cfg.amplitude}, 8'h02, "amp");
    check_byte({6'h0, cfg.pll_mode}, {6'h0, strap}, "mode");
    bus_read(8'h00, 8'h08, '{8'hff, {strap, 6'h02}, 8'hff});
  endtask : sc_defaults
  // Write three bytes, refuse a fourth, read them back
  task automatic sc_write();
    bus_write(8'h00, 8'h03, '{8'h41, 8'h39, 8'h0a, 8'h55});
    check_byte({2'h0, cfg.out_run}, 8'h11, "run");
    check_byte({2'h0, cfg.edge_speed}, 8'h04, "slew");
    check_byte({6'h0, cfg.amplitude}, 8'h01, "amp");
    check_byte({6'h0, cfg.pll_mode}, 8'h03, "sw mode");
    bus_read(8'h00, 8'h08, '{8'h63, {strap, 6'h39}, 8'h2a});
  endtask : sc_write
  // Written mode bits idle while the source select is clear
  task automatic sc_mode_src();
    bus_write(8'h01, 8'h01, '{8'h1b});
    check_byte({6'h0, cfg.pll_mode}, {6'h0, strap}, "mode");
    check_byte({6'h0, cfg.amplitude}, 8'h03, "amp");
  endtask : sc_mode_src
  // Enable pins gate only outputs whose bit is set; cleared bits win
  task automatic sc_pins();
    out_pin_en_n <= 6'h10;
    repeat (6) @(posedge mclk);
    check_byte({2'h0, cfg.out_run}, 8'h01, "pins");
    out_pin_en_n <= 6'h00;
    repeat (6) @(posedge mclk);
    bus_write(8'h00, 8'h01, '{8'h00});
    check_byte({2'h0, cfg.out_run}, 8'h00, "off");
  endtask : sc_pins
  // Count byte eight returned at the start of a read
  task automatic sc_count();
    bus_write(8'h08, 8'h01, '{8'h02});
    bus_read(8'h01, 8'h02, '{{strap, 6'h1b}, 8'h2a});
  endtask : sc_count
  // Address follows the select pin latched after reset
  task automatic sc_address();
    probe(7'h6c, 1'b0);
    strap <= 2'h1;
    do_reset(2'h1);
    probe(7'h6b, 1'b0);
    dev_addr = 7'h6c;
    check_byte({6'h0, cfg.pll_mode}, 8'h01, "mode");
    bus_read(8'h00, 8'h08, '{8'hff, {strap, 6'h02}});
    do_reset(2'h2);
    probe(7'h6c, 1'b0);
    probe(7'h6d, 1'b1);
  endtask : sc_address
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    do_reset(2'h0);
    sc_defaults();
    sc_write();
    sc_mode_src();
    sc_pins();
    sc_count();
    sc_address();
    tally_and_finish();
  end
endmodule : test_scb_target
